//--- core/ram_array.v
// Storage array with byte-lane writes and a registered read port.
// Assumes one clock; read and write addresses come from the port logic.
`timescale 1ns/1ps
`default_nettype none
`include "ram_port_defines.vh"

module ram_array (
	input wire ref_clk,
	input wire [`ADDR_W-1:0] addr,
	input wire wr_en,
	input wire [1:0] lane_en,
	input wire [`DATA_W-1:0] wr_data,
	output wire [`DATA_W-1:0] rd_data
);
	//----------------------------------------
	// Write and read
	//----------------------------------------
	// One array per byte lane, so each lane's store has a single process
	genvar b;
	generate
		for (b = 0; b < `DATA_W/`BYTE_W; b = b + 1) begin : g_lane
			reg [`BYTE_W-1:0] mem [0:`DEPTH-1];
			reg [`BYTE_W-1:0] rd_lane_reg;
			// Read before write: a read in the write cycle returns old contents
			always @(posedge ref_clk) begin
				if (wr_en && lane_en[b]) begin
					mem[addr] <= wr_data[b*`BYTE_W +: `BYTE_W];
				end
				rd_lane_reg <= mem[addr];
			end
			assign rd_data[b*`BYTE_W +: `BYTE_W] = rd_lane_reg;
		end
	endgenerate
endmodule // ram_array

`default_nettype wire

//--- core/ram_port_defines.vh
// Constants for one port of a synchronous dual-port RAM.
// Assumes inclusion by bare name from the port and memory modules.
`ifndef RAM_PORT_DEFINES_VH
`define RAM_PORT_DEFINES_VH

//----------------------------------------
// Geometry
//----------------------------------------
`define ADDR_W 15
`define DATA_W 16
`define DEPTH 32768
`define BYTE_W 8

//----------------------------------------
// Reset values
//----------------------------------------
`define ADDR_ZERO 15'h0000
`define DATA_ZERO 16'h0000

`endif

//--- core/sync_dual_port_ram_port.v
// One port of a synchronous dual-port RAM: registered inputs, address
// counter, select power-down and flow-through or pipelined output.
// Assumes every input but output_enable_n is synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ram_port_defines.vh"

module sync_dual_port_ram_port (
	input wire ref_clk,
	input wire arst_n,
	input wire chip_select_low_active,
	input wire chip_select_high_active,
	input wire read_write,
	input wire output_enable_n,
	input wire address_strobe_n,
	input wire counter_advance_n,
	input wire counter_clear_n,
	input wire upper_byte_select_n,
	input wire lower_byte_select_n,
	input wire output_latency_select,
	input wire [`ADDR_W-1:0] addr_in,
	input wire [`DATA_W-1:0] data_in,
	output reg [`DATA_W-1:0] data_out,
	output reg [`DATA_W-1:0] data_oe,
	output reg powered_down
);
	//----------------------------------------
	// Input registers
	//----------------------------------------
	reg sel_reg;
	reg wr_reg;
	reg ld_reg;
	reg adv_reg;
	reg clr_reg;
	reg [1:0] lane_reg;
	reg [`ADDR_W-1:0] ext_addr_reg;
	reg [`DATA_W-1:0] din_reg;
	reg [`ADDR_W-1:0] count_reg;
	reg [`ADDR_W-1:0] addr_next;
	reg sel_prev_reg;
	reg wake_reg;
	reg [1:0] lane_rd_reg;
	reg rd_ok_reg;
	reg [`DATA_W-1:0] pipe_reg;
	reg [1:0] pipe_lane_reg;
	reg pipe_ok_reg;
	wire [`DATA_W-1:0] arr_data;
	wire sel_now;

	assign sel_now = ~chip_select_low_active & chip_select_high_active;

	// Capture all controls but output_enable_n and output_latency_select, address and data on the rising edge
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_reg <= 1'b0;
			wr_reg <= 1'b0;
			ld_reg <= 1'b0;
			adv_reg <= 1'b0;
			clr_reg <= 1'b0;
			lane_reg <= 2'b00;
			ext_addr_reg <= `ADDR_ZERO;
			din_reg <= `DATA_ZERO;
		end else begin
			sel_reg <= sel_now;
			wr_reg <= ~read_write;
			ld_reg <= ~address_strobe_n;
			adv_reg <= ~counter_advance_n;
			clr_reg <= ~counter_clear_n;
			lane_reg <= {~upper_byte_select_n, ~lower_byte_select_n};
			ext_addr_reg <= addr_in;
			din_reg <= data_in;
		end
	end

	//----------------------------------------
	// Access address
	//----------------------------------------
	// Clear first, then load, then advance; else hold the counter
	always @* begin
		if (clr_reg) begin
			addr_next = `ADDR_ZERO;
		end else if (ld_reg) begin
			addr_next = ext_addr_reg;
		end else if (adv_reg) begin
			addr_next = count_reg + 1'b1;
		end else begin
			addr_next = count_reg;
		end
	end

	// Counter follows the access address so the next cycle continues from it
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= `ADDR_ZERO;
		end else begin
			count_reg <= addr_next;
		end
	end

	// Write strobe is derived internally from the registered controls
	ram_array u_array (
		.ref_clk(ref_clk),
		.addr(addr_next),
		.wr_en(sel_reg & wr_reg),
		.lane_en(lane_reg),
		.wr_data(din_reg),
		.rd_data(arr_data)
	);

	//----------------------------------------
	// Output staging
	//----------------------------------------
	// Array data appears one edge after the registered address: this is
	// the flow-through stage; pipelined mode adds one more stage.
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_prev_reg <= 1'b0;
			wake_reg <= 1'b0;
			lane_rd_reg <= 2'b00;
			rd_ok_reg <= 1'b0;
			pipe_reg <= `DATA_ZERO;
			pipe_lane_reg <= 2'b00;
			pipe_ok_reg <= 1'b0;
		end else begin
			sel_prev_reg <= sel_reg;
			// Select of the access before the one now in rd_ok_reg
			wake_reg <= sel_prev_reg;
			lane_rd_reg <= lane_reg;
			rd_ok_reg <= sel_reg & ~wr_reg;
			pipe_reg <= arr_data;
			pipe_lane_reg <= lane_rd_reg;
			// Pipelined outputs need this access and the one before selected
			pipe_ok_reg <= rd_ok_reg & wake_reg;
		end
	end

	//----------------------------------------
	// Data pins
	//----------------------------------------
	// Output enable is sampled here because outputs must come from flops;
	// a true asynchronous gate belongs in the pad ring driven by data_oe.
	genvar i;
	generate
		for (i = 0; i < `DATA_W; i = i + 1) begin : g_pin
			always @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					data_out[i] <= 1'b0;
					data_oe[i] <= 1'b0;
				end else if (output_latency_select) begin
					data_out[i] <= pipe_reg[i];
					data_oe[i] <= pipe_ok_reg & pipe_lane_reg[i/`BYTE_W] & ~output_enable_n;
				end else begin
					data_out[i] <= arr_data[i];
					data_oe[i] <= rd_ok_reg & lane_rd_reg[i/`BYTE_W] & ~output_enable_n;
				end
			end
		end
	endgenerate

	// Power-down status for the rest of the chip
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			powered_down <= 1'b1;
		end else begin
			powered_down <= ~sel_reg;
		end
	end
endmodule // sync_dual_port_ram_port

`default_nettype wire

//--- test/io_pad_model.sv
// Board pads for the data pins; a floated bit shows the inverse value.
// Assumes output_enable_n reaches the pads with no clock.
`timescale 1ns/1ps
`default_nettype none
module io_pad_model(
	input wire logic [15:0] data_out,
	input wire logic [15:0] data_oe,
	input wire logic output_enable_n,
	output logic [15:0] pin
);
	// Gate by the pin itself so a stale flop never passes
	assign pin = ~((data_oe & {16{!output_enable_n}}) ^ data_out);
endmodule // io_pad_model
`default_nettype wire

//--- test/ram_port_sva.sv
// Checker for one RAM port, on the port's pins only.
// Assumes inputs change away from the rising edge.
`timescale 1ns/1ps
`default_nettype none
module ram_port_sva(
	input wire ref_clk,
	input wire arst_n,
	input wire chip_select_low_active,
	input wire chip_select_high_active,
	input wire read_write,
	input wire output_enable_n,
	input wire address_strobe_n,
	input wire counter_advance_n,
	input wire counter_clear_n,
	input wire upper_byte_select_n,
	input wire output_latency_select,
	input wire [15:0] data_out,
	input wire [15:0] data_oe,
	input wire powered_down
);
	// Depth differs by mode, so each select or lane float check names its mode
	wire sel = !chip_select_low_active && chip_select_high_active;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence hold_s;
		sel && read_write && address_strobe_n && counter_advance_n && counter_clear_n;
	endsequence
	sequence wake_s;
		output_latency_select && !sel ##1 sel;
	endsequence
	idle_reset_a: assert property ($rose(arst_n) |-> powered_down && data_oe == 16'h0)
		else $error("port busy after reset");
	power_down_a: assert property (!sel |-> ##[1:2] powered_down) else $error("no power-down");
	power_up_a: assert property (sel [*3] |-> !powered_down) else $error("still down");
	ft_float_a: assert property (!sel && !output_latency_select |-> ##3 data_oe == 16'h0)
		else $error("deselected read drove");
	pipe_wake_a: assert property (wake_s |-> ##4 data_oe == 16'h0) else $error("early wake");
	lane_float_a: assert property (!output_latency_select && sel && read_write &&
		upper_byte_select_n |-> ##3 data_oe[15:8] == 8'h0) else $error("upper lane drove");
	oe_gate_a: assert property (output_enable_n [*7] |-> data_oe == 16'h0) else $error("oe");
	hold_data_a: assert property (hold_s [*7] |-> $stable(data_out)) else $error("drift");
endmodule // ram_port_sva
bind sync_dual_port_ram_port ram_port_sva u_sva(.*);
`default_nettype wire

//--- test/sync_dual_port_ram_port_bench.sv
// Bench for one RAM port: counter, select, lane and latency.
// Assumes the pad model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module sync_dual_port_ram_port_bench;
	localparam logic [8:0] RD = 9'h168, WR = 9'h068;
	logic ref_clk = 0, arst_n = 0, rw, stb_n, adv_n, clr_n, csl, csh, hi_n, lo_n, oe_n;
	logic lat = 0, rd = 0, psel = 0;
	logic [14:0] a = 0, cur = 0;
	logic [15:0] d = 0, dout, doe, pin;
	logic [15:0] mem [logic [14:0]];
	logic [31:0] exq [$];
	logic [7:0] hist = 0;
	logic [1:0] sh = 0;
	logic oe_last = 1, pd;
	logic [8:0] tv [7] = '{RD ^ 9'h010, RD, RD, RD ^ 9'h008, RD, RD ^ 9'h004, RD ^ 9'h002};
	int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 32'hb95c;
	always #4 ref_clk = ~ref_clk;
	sync_dual_port_ram_port u_dut(.ref_clk, .arst_n, .chip_select_low_active(csl),
		.chip_select_high_active(csh), .read_write(rw), .output_enable_n(oe_n),
		.address_strobe_n(stb_n), .counter_advance_n(adv_n), .counter_clear_n(clr_n),
		.upper_byte_select_n(hi_n), .lower_byte_select_n(lo_n), .output_latency_select(lat),
		.addr_in(a), .data_in(d), .data_out(dout), .data_oe(doe), .powered_down(pd));
	io_pad_model u_pad(.data_out(dout), .data_oe(doe), .output_enable_n(oe_n), .pin);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// One access; the counter model picks clear, then load, then advance
	task automatic go(input logic [8:0] c, input logic [14:0] ad, input logic [15:0] dd);
		@(negedge ref_clk);
		{rw, stb_n, adv_n, clr_n, csl, csh, hi_n, lo_n, oe_n} = c;
		a = ad;
		d = dd;
		cur = !clr_n ? 15'h0 : !stb_n ? ad : !adv_n ? cur + 15'h1 : cur;
		rd = rw && mem.exists(cur);
		if (!rw) mem[cur] = dd;
		if (rd) exq.push_back(!csl && csh && (psel || !lat) ?
			{~{{8{hi_n}}, {8{lo_n}}}, mem[cur]} : 32'h0);
		psel = !csl && csh;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Results land three falling edges on, four when pipelined; the drive
	// mask takes output_enable_n as the output flop saw it one edge before
	always @(negedge ref_clk) begin
		logic [15:0] drv;
		#1;
		hist = {hist[6:0], rd};
		rd = 0;
		if (hist[2]) chk({15'h0, pd}, {15'h0, ~sh[1]});
		if (hist[lat ? 4 : 3]) begin
			drv = exq[0][31:16] & {16{!oe_last}};
			chk(doe, drv);
			drv = drv & {16{!oe_n}};
			chk(pin & drv, exq[0][15:0] & drv);
			void'(exq.pop_front());
		end
		sh = {sh[0], !csl && csh};
		oe_last = oe_n;
		if (++cyc == 2000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial begin
		logic [31:0] r;
		{rw, stb_n, adv_n, clr_n, csl, csh, hi_n, lo_n, oe_n} = RD;
		for (int p = 0; p < 2; p++) begin
			arst_n = 0;
			lat = p[0];
			repeat (6) @(negedge ref_clk);
			arst_n = 1;
			for (int i = 0; i < 8; i++) go(WR, 15'(i), 16'(i * 16'h1111));
			repeat (60) begin
				r = $random(seed);
				go({r[3:0], 5'h08}, {12'h0, r[6:4]}, r[31:16]);
			end
			go(WR ^ 9'h020, 15'h5, 16'h5a5a);
			repeat (8) go(RD ^ 9'h080, 15'h0, 16'h0);
			foreach (tv[k]) go(tv[k], 15'(k), 16'h0);
			repeat (3) go(RD, 15'h2, 16'h0);
			repeat (7) go(RD ^ 9'h001, 15'h1, 16'h0);
			go(RD, 15'h2, 16'h0);
			repeat (8) @(negedge ref_clk);
			$display("mode %0d done", p);
		end
		tally_and_finish;
	end
endmodule // sync_dual_port_ram_port_bench
`default_nettype wire
